// [hw/link_quality_threshold_access.sv]
// avalon register front end for link quality thresholds and sampling
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`include "lq_cfg.svh"

module link_quality_threshold_access
   import lq_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // avalon-mm slave
   input  wire logic [4:0]      avs_address,
   input  wire logic            avs_read,
   input  wire logic            avs_write,
   input  wire logic [31:0]     avs_writedata,
   input  wire logic [3:0]      avs_byteenable,
   output logic [31:0]          avs_readdata,
   output logic                 avs_waitrequest,
   // adapted receiver parameters
   input  wire lq_pkg::byte_type eq_c1_value,
   input  wire lq_pkg::byte_type gain_value,
   input  wire lq_pkg::byte_type wander_value,
   input  wire lq_pkg::byte_type freq_offset_value,
   input  wire lq_pkg::byte_type freq_control_value,
   // device state
   input  wire logic            link_100_ok,
   input  wire logic            powered_down,
   // interrupt
   output logic                 irq
);

   import lq_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0]     data_q;
   logic [15:0]     data_d;
   byte_type        sampled_q;
   byte_type        sampled_d;
   logic            mon_en_q;
   logic            mon_en_d;
   warn_type        warn_q;
   warn_type        warn_d;
   warn_type        stat_q;
   warn_type        stat_d;
   warn_type        ien_q;
   warn_type        ien_d;
   logic            armed_q;
   logic            armed_d;
   logic            ack_q;
   logic            ack_d;
   logic [31:0]     rdata_q;
   logic [31:0]     rdata_d;

   thr_access_if    thr ();

   param_vec_type   param_vec;

   // ------------------------------------------------------------------
   // bus handshake: one wait cycle, answer on the second cycle
   // ------------------------------------------------------------------
   wire req     = avs_read | avs_write;
   wire wr_go   = avs_write & ack_q;
   wire rd_go   = avs_read & ack_q;
   wire rd_cap  = avs_read & ~ack_q;

   assign avs_waitrequest = req & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign ack_d           = req & ~ack_q;

   // ------------------------------------------------------------------
   // address decode; anything else reads zero and drops writes
   // ------------------------------------------------------------------
   wire hit_data = (avs_address == `LQ_OFS_DATA);
   wire hit_mon  = (avs_address == `LQ_OFS_MON);
   wire hit_stat = (avs_address == `LQ_OFS_STAT);
   wire hit_clr  = (avs_address == `LQ_OFS_CLR);
   wire hit_ien  = (avs_address == `LQ_OFS_IEN);

   // byte lanes 0 and 1 cover every implemented bit
   wire [15:0] lane_mask = {{8{avs_byteenable[1]}},
                            {8{avs_byteenable[0]}}};
   wire [15:0] wd16      = avs_writedata[15:0] & lane_mask;

   // ------------------------------------------------------------------
   // threshold data register write path
   // ------------------------------------------------------------------
   wire        data_we  = wr_go & hit_data;
   wire [15:0] data_wr  = (data_q & ~lane_mask) | wd16;

   // strobe and reserved bits never get stored
   assign data_d = data_we ? (data_wr & `LQ_DATA_WMASK) : data_q;

   wire [2:0] sel_wr   = data_wr[`LQ_SEL_MSB:`LQ_SEL_LSB];
   wire       sel_ok_w = (sel_wr <= `LQ_SEL_MAX);
   wire       strobe   = data_we & data_wr[`LQ_STROBE_BIT];

   // powered down blocks the store, the register fields still update
   assign thr.we    = strobe & sel_ok_w & ~powered_down;
   assign thr.widx  = {sel_wr, data_wr[`LQ_HL_BIT]};
   assign thr.wdata = data_wr[`LQ_VAL_MSB:0];

   // ------------------------------------------------------------------
   // threshold read path, indexed by the stored fields
   // ------------------------------------------------------------------
   wire [2:0] sel_q       = data_q[`LQ_SEL_MSB:`LQ_SEL_LSB];
   wire       sample_mode = data_q[`LQ_SAMPLE_BIT];

   assign thr.ridx = {sel_q, data_q[`LQ_HL_BIT]};

   lq_threshold_bank u_bank (
      .clk  (clk),
      .rst  (rst),
      .port (thr.bank)
   );

   // ------------------------------------------------------------------
   // parameter sampling
   // ------------------------------------------------------------------
   assign param_vec[SEL_EQ_C1]    = eq_c1_value;
   assign param_vec[SEL_GAIN]     = gain_value;
   assign param_vec[SEL_WANDER]   = wander_value;
   assign param_vec[SEL_FREQ_OFS] = freq_offset_value;
   assign param_vec[SEL_FREQ_CTL] = freq_control_value;

   // every write carrying the sample bit starts a fresh sample, so
   // software can re-sample without first clearing the bit
   wire      sample_go  = data_we & data_wr[`LQ_SAMPLE_BIT];
   wire      sel_ok_s   = (sel_wr <= `LQ_SEL_MAX);
   byte_type sample_new;

   assign sample_new = sel_ok_s ? param_vec[sel_wr] : `LQ_BYTE_RST;
   assign sampled_d  = sample_go ? sample_new : sampled_q;

   // data field shows the sample or the selected threshold
   wire [7:0] data_field = sample_mode ? sampled_q : thr.rdata;

   wire [15:0] data_rd = {2'b00,
                          data_q[`LQ_SAMPLE_BIT],
                          1'b0,
                          data_q[`LQ_SEL_MSB:`LQ_HL_BIT],
                          data_field};

   // ------------------------------------------------------------------
   // threshold monitor
   // ------------------------------------------------------------------
   wire mon_on = mon_en_q & link_100_ok;
   warn_type warn_set;

   // below low or above high raises the warning of that direction;
   // setting a low threshold to 00 or a high threshold to ff effectively disables it
   generate
      for (genvar p = 0; p < `LQ_NUM_PARAM; p++) begin : g_cmp
         assign warn_set[2*p]   = mon_on &
                                  (param_vec[p] < thr.low[p]);
         assign warn_set[2*p+1] = mon_on &
                                  (param_vec[p] > thr.high[p]);
      end
   endgenerate

   wire rd_mon = rd_go & hit_mon;

   // a crossing in the read cycle survives the clear
   assign warn_d = (warn_q & ~{10{rd_mon}}) | warn_set;

   // monitor enable sits in lane 1
   assign mon_en_d = (wr_go & hit_mon & avs_byteenable[1]) ?
                     avs_writedata[`LQ_EN_BIT] : mon_en_q;

   // ------------------------------------------------------------------
   // interrupt: one event per newly set warning while armed
   // ------------------------------------------------------------------
   wire [9:0] warn_new = warn_set & ~warn_q;
   wire [9:0] event_v  = warn_new & {10{armed_q}};
   wire       fired    = |(event_v & ien_q);

   // a monitor read re-arms from the next cycle; only an enabled event seen while armed disarms
   assign armed_d = (armed_q | rd_mon) & ~fired;

   wire       clr_we  = wr_go & hit_clr;
   wire [9:0] clr_v   = wd16[`LQ_WARN_MSB:0] & {10{clr_we}};

   // set wins over clear
   assign stat_d = (stat_q & ~clr_v) | event_v;

   wire [9:0] ien_wr = (ien_q & ~lane_mask[`LQ_WARN_MSB:0]) |
                       wd16[`LQ_WARN_MSB:0];
   assign ien_d = (wr_go & hit_ien) ? ien_wr : ien_q;

   assign irq = |(stat_q & ien_q);

   // ------------------------------------------------------------------
   // read data, captured in the wait cycle and held for the answer
   // ------------------------------------------------------------------
   wire [31:0] rd_mux =
      hit_data ? {16'h0000, data_rd} :
      hit_mon  ? {16'h0000, mon_en_q, 5'h00, warn_q} :
      hit_stat ? {22'h000000, stat_q} :
      hit_ien  ? {22'h000000, ien_q} :
                 32'h0000_0000;

   assign rdata_d = rd_cap ? rd_mux : rdata_q;

   // ------------------------------------------------------------------
   // register updates
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         data_q    <= `LQ_DATA_RST;
         sampled_q <= `LQ_BYTE_RST;
      end else begin
         data_q    <= data_d;
         sampled_q <= sampled_d;
      end
   end

   // monitor and interrupt state
   always_ff @(posedge clk) begin
      if (rst) begin
         mon_en_q <= `LQ_FLAG_RST;
         warn_q   <= `LQ_WARN_RST;
         stat_q   <= `LQ_WARN_RST;
         ien_q    <= `LQ_WARN_RST;
         armed_q  <= `LQ_ARMED_RST;
      end else begin
         mon_en_q <= mon_en_d;
         warn_q   <= warn_d;
         stat_q   <= stat_d;
         ien_q    <= ien_d;
         armed_q  <= armed_d;
      end
   end

   // bus answer state
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q   <= `LQ_FLAG_RST;
         rdata_q <= `LQ_RDATA_RST;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
      end
   end

endmodule : link_quality_threshold_access

// [hw/lq_cfg.svh]
// constants for the link quality threshold access block
`ifndef LQ_CFG_SVH
`define LQ_CFG_SVH

// register byte offsets on the avalon slave
`define LQ_OFS_DATA     5'h00
`define LQ_OFS_MON      5'h04
`define LQ_OFS_STAT     5'h08
`define LQ_OFS_CLR      5'h0c
`define LQ_OFS_IEN      5'h10

// threshold data register fields
`define LQ_SAMPLE_BIT   13
`define LQ_STROBE_BIT   12
`define LQ_SEL_MSB      11
`define LQ_SEL_LSB      9
`define LQ_HL_BIT       8
`define LQ_VAL_MSB      7
`define LQ_DATA_WMASK   16'h2fff
`define LQ_DATA_RST     16'h0000

// monitor control register fields
`define LQ_EN_BIT       15
`define LQ_WARN_MSB     9

// parameter count and last valid select code
`define LQ_NUM_PARAM    5
`define LQ_NUM_THR      10
`define LQ_SEL_MAX      3'h4

// reset values of the remaining registers
`define LQ_BYTE_RST     8'h00
`define LQ_WARN_RST     10'h000
`define LQ_FLAG_RST     1'b0
`define LQ_ARMED_RST    1'b1
`define LQ_RDATA_RST    32'h0000_0000

`endif

// [hw/lq_pkg.sv]
// types shared by the link quality threshold access block
package lq_pkg;

   typedef logic [7:0]          byte_type;
   typedef logic [3:0]          thr_idx_type;
   typedef logic [9:0]          warn_type;
   typedef logic [4:0][7:0]     param_vec_type;

   // monitored parameter codes
   typedef enum logic [2:0] {
      SEL_EQ_C1     = 3'h0,
      SEL_GAIN      = 3'h1,
      SEL_WANDER    = 3'h2,
      SEL_FREQ_OFS  = 3'h3,
      SEL_FREQ_CTL  = 3'h4
   } param_sel_type;

endpackage : lq_pkg

// [hw/lq_threshold_bank.sv]
// ten threshold registers, low and high for each parameter
`include "lq_cfg.svh"

module lq_threshold_bank
   import lq_pkg::*;
(
   // clock and reset
   input wire logic     clk,
   input wire logic     rst,
   // access port
   thr_access_if.bank   port
);

   byte_type thr_q [`LQ_NUM_THR];

   // index is {select, low/high}, so even entries are low thresholds
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `LQ_NUM_THR; i++) begin
            thr_q[i] <= `LQ_BYTE_RST;
         end
      end else if (port.we && port.widx < 4'(`LQ_NUM_THR)) begin
         thr_q[port.widx] <= port.wdata;
      end
   end

   // unassigned codes land at index 10 and above and read zero
   assign port.rdata = (port.ridx < 4'(`LQ_NUM_THR)) ?
                       thr_q[port.ridx] : `LQ_BYTE_RST;

   // all thresholds fan out to the comparators
   generate
      for (genvar p = 0; p < `LQ_NUM_PARAM; p++) begin : g_fan
         assign port.low[p]  = thr_q[2*p];
         assign port.high[p] = thr_q[2*p+1];
      end
   endgenerate

endmodule : lq_threshold_bank

// [hw/thr_access_if.sv]
// carrier between the register front end and the threshold store
interface thr_access_if;
   import lq_pkg::*;

   logic          we;
   thr_idx_type   widx;
   byte_type      wdata;
   thr_idx_type   ridx;
   byte_type      rdata;
   param_vec_type low;
   param_vec_type high;

   modport bank (
      input  we,
      input  widx,
      input  wdata,
      input  ridx,
      output rdata,
      output low,
      output high
   );

   modport user (
      output we,
      output widx,
      output wdata,
      output ridx,
      input  rdata,
      input  low,
      input  high
   );

endinterface : thr_access_if

// [testbench/link_quality_threshold_access_tb.sv]
// self-checking bench for the link quality threshold access block
module link_quality_threshold_access_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import lq_pkg::*;

   logic        clk;
   logic        rst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        link_100_ok;
   logic        powered_down;
   logic        irq;
   byte_type    prm [5];
   int          err_total;
   int          compares;

   link_quality_threshold_access dut (
      .clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .eq_c1_value(prm[0]), .gain_value(prm[1]), .wander_value(prm[2]),
      .freq_offset_value(prm[3]), .freq_control_value(prm[4]),
      .link_100_ok(link_100_ok), .powered_down(powered_down), .irq(irq));

   // free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string s, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   // one bus access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // no local limit: a hung handshake is ended by the watchdog
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // an idle edge keeps one driver per signal per time step
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input string s, input logic [4:0] a,
                      input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(s, e, q);
   endtask : rdc

   function automatic logic [7:0] tv(input int i);
      tv = i[0] ? 8'he0 + 8'(i) : 8'h10 + 8'(i);
   endfunction : tv

   task automatic t_reset;
      rdc("data reg", 5'h00, 32'h0);
      rdc("irq enable", 5'h10, 32'h0);
      rdc("unmapped", 5'h14, 32'h0);
   endtask : t_reset

   // all ten thresholds written first, so aliasing shows up on readback
   task automatic t_thr;
      for (int i = 0; i < 10; i++)
         wr(5'h00, {16'h0, 4'hd, 4'(i), tv(i)});
      for (int i = 0; i < 10; i++) begin
         wr(5'h00, {20'h0, 4'(i), 8'h00});
         rdc("threshold", 5'h00, {20'h0, 4'(i), tv(i)});
      end
      for (int s = 5; s < 8; s++) begin
         wr(5'h00, {19'h0, 1'b1, 3'(s), 1'b0, 8'h5a});
         rdc("bad select", 5'h00, {20'h0, 3'(s), 9'h0});
      end
      powered_down <= 1'b1;
      wr(5'h00, 32'h00001077);
      powered_down <= 1'b0;
      rdc("powered down", 5'h00, 32'h00000010);
   endtask : t_thr

   // live values change after the capture and must not leak through
   task automatic t_sample;
      for (int k = 0; k < 5; k++)
         prm[k] <= 8'h30 + 8'(k);
      for (int k = 0; k < 5; k++) begin
         wr(5'h00, {18'h0, 2'b10, 3'(k), 9'h0});
         prm[k] <= 8'hff;
         rdc("sample", 5'h00, {18'h0, 2'b10, 3'(k), 1'b0,
             8'h30 + 8'(k)});
      end
      for (int k = 0; k < 5; k++)
         prm[k] <= 8'h80;
   endtask : t_sample

   task automatic t_mon;
      wr(5'h10, 32'h3ff);
      wr(5'h04, 32'h8000);
      prm[0] <= 8'h00;
      repeat (4) @(posedge clk);
      rdc("status link down", 5'h08, 32'h0);
      link_100_ok <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      // gain over its high limit while disarmed must not set status
      prm[1] <= 8'hff;
      repeat (2) @(posedge clk);
      rdc("status", 5'h08, 32'h1);
      rdc("warnings", 5'h04, 32'h8009);
      prm[0] <= 8'h80;
      prm[1] <= 8'h80;
      repeat (4) @(posedge clk);
      // warnings stay latched until the read that returns them
      rdc("warnings latched", 5'h04, 32'h8009);
      rdc("warnings cleared", 5'h04, 32'h8000);
      wr(5'h0c, 32'h1);
      rdc("status cleared", 5'h08, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(5'h10, 32'h0);
      prm[0] <= 8'hff;
      repeat (4) @(posedge clk);
      rdc("status masked", 5'h08, 32'h2);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(5'h10, 32'h2);
      chk("irq enabled", 32'h1, {31'h0, irq});
      prm[0] <= 8'h80;
   endtask : t_mon

   // back-to-back reads: read stays high, only the address moves
   task automatic t_b2b;
      logic [31:0] q;
      avs_address <= 5'h10;
      avs_read <= 1'b1;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_address <= 5'h08;
      chk("b2b irq enable", 32'h00000002, q);
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      chk("b2b status", 32'h00000002, q);
      @(posedge clk);
   endtask : t_b2b

   task automatic print_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // a hung handshake ends the run here
   initial begin
      #(25 * 4000);
      err_total++;
      print_verdict();
   end

   // reset, then each scenario in turn
   initial begin
      err_total = 0;
      compares = 0;
      rst = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      link_100_ok = 1'b0;
      powered_down = 1'b0;
      for (int k = 0; k < 5; k++)
         prm[k] = 8'h80;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_thr();
      t_sample();
      t_mon();
      t_b2b();
      print_verdict();
   end
endmodule : link_quality_threshold_access_tb

bind link_quality_threshold_access lq_access_asserts chk_i (
   .clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .irq(irq));

// [testbench/lq_access_asserts.sv]
// bus timing and register read checks for the threshold access block
module lq_access_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // bus side
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 100ps;

   logic req;
   logic rd_ok;
   logic rd0;
   logic fresh_q;
   logic fresh_d;

   // accesses qualified at the edge where the slave answers
   assign req   = avs_read | avs_write;
   assign rd_ok = avs_read & ~avs_waitrequest;
   assign rd0   = rd_ok & (avs_address == 5'h00);
   // only ports are visible, so reset state is trusted until the first data register write
   assign fresh_d = fresh_q & ~(avs_write & ~avs_waitrequest
                                & (avs_address == 5'h00));

   // marks the span since reset
   always_ff @(posedge clk) begin
      if (rst) fresh_q <= 1'b1;
      else fresh_q <= fresh_d;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_one_wait;
      req && avs_waitrequest |=> !avs_waitrequest || !req;
   endproperty
   property p_idle;
      !req |-> !avs_waitrequest;
   endproperty
   property p_b2b;
      req && !avs_waitrequest ##1 req |-> avs_waitrequest;
   endproperty
   property p_rsv;
      rd0 |-> avs_readdata[31:14] == 18'h00000;
   endproperty
   property p_strobe;
      rd0 |-> !avs_readdata[12];
   endproperty
   property p_badsel;
      rd0 && !avs_readdata[13] && avs_readdata[11:9] > 3'h4
         |-> avs_readdata[7:0] == 8'h00;
   endproperty
   property p_rstval;
      rd0 && fresh_q |-> avs_readdata[15:8] == 8'h00;
   endproperty
   property p_unmapped;
      rd_ok && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10})
         |-> avs_readdata == 32'h00000000;
   endproperty

   a_one_wait: assert property (p_one_wait)
      else $error("waitrequest longer than one cycle");
   a_idle: assert property (p_idle)
      else $error("waitrequest without a request");
   a_b2b: assert property (p_b2b)
      else $error("second access answered without a wait");
   a_rsv: assert property (p_rsv)
      else $error("reserved data bits not zero");
   a_strobe: assert property (p_strobe)
      else $error("write strobe reads back set");
   a_badsel: assert property (p_badsel)
      else $error("unassigned select returns data");
   a_rstval: assert property (p_rstval)
      else $error("data register fields not reset");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address returns data");

   c_sample: cover property (rd0 && avs_readdata[13]);
   c_irq: cover property (irq);
   c_b2b: cover property (req && !avs_waitrequest ##1 req);
endmodule : lq_access_asserts
